/* src/cgc_pkg.sv */
// shared constants, register map and carrier types of the counter gate control block
package cgc_pkg;

    // structure
    localparam int CGC_NCH = 8; // channel count
    localparam int CGC_CW = 32; // counter width
    localparam int CGC_AW = 8; // byte address width of the register window

    // register byte offsets
    localparam logic [7:0] CGC_OFS_SOFT = 8'h00; // soft gate control bits
    localparam logic [7:0] CGC_OFS_HWEN = 8'h04; // hard gate configured per channel
    localparam logic [7:0] CGC_OFS_CANCEL = 8'h08; // 1 cancel, 0 interrupt
    localparam logic [7:0] CGC_OFS_AUTO = 8'h0c; // auto stop at end value
    localparam logic [7:0] CGC_OFS_LOAD = 8'h10; // write 1 loads start value, reads 0
    localparam logic [7:0] CGC_OFS_STATUS = 8'h14; // gate states, read only
    localparam logic [2:0] CGC_BLK_START = 3'h2; // 0x40..0x5c start value per channel
    localparam logic [2:0] CGC_BLK_END = 3'h3; // 0x60..0x7c end value per channel
    localparam logic [2:0] CGC_BLK_COUNT = 3'h4; // 0x80..0x9c count value per channel

    // status field positions
    localparam int CGC_ST_GATE_LSB = 0; // internal gate bits
    localparam int CGC_ST_SOFT_LSB = 8; // soft gate open bits
    localparam int CGC_ST_HARD_LSB = 16; // hard gate open bits

    // reset values
    localparam logic [7:0] CGC_RST_SOFT = 8'h00;
    localparam logic [7:0] CGC_RST_HWEN = 8'h00;
    localparam logic [7:0] CGC_RST_CANCEL = 8'h00;
    localparam logic [7:0] CGC_RST_AUTO = 8'h00;
    localparam logic [31:0] CGC_RST_START = 32'h00000000;
    localparam logic [31:0] CGC_RST_END = 32'hffffffff;
    localparam logic [31:0] CGC_RST_COUNT = 32'h00000000;

    // per channel configuration carried together
    typedef struct packed {
        logic hw_en; // hard gate configured
        logic cancel; // close cancels instead of interrupting
        logic auto_stop; // count value may close the gate
    } cgc_cfg_t;

    // status word layout, gate bits lowest
    typedef struct packed {
        logic [7:0] hard_open;
        logic [7:0] soft_open;
        logic [7:0] gate;
    } cgc_stat_t;

endpackage : cgc_pkg

/* src/cgc_sync.sv */
// two flop synchroniser with a third stage for edge detection
`timescale 1ns/1ps
module cgc_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_r; // first stage, read only by the second
    logic [W-1:0] sync_r; // settled level
    logic [W-1:0] last_r; // previous settled level

    // chain runs through reset too, so a pin already high at release is no edge
    always_ff @(posedge clk) begin
        meta_r <= din;
        sync_r <= meta_r;
        last_r <= sync_r;
    end

    assign lvl = sync_r;
    // edges are masked while reset is held
    assign rise = sync_r & ~last_r & ~{W{rst}};
    assign fall = ~sync_r & last_r & ~{W{rst}};

endmodule : cgc_sync

/* src/cgc_count.sv */
// one channel counter: load, hold, step and end value hit
`timescale 1ns/1ps
module cgc_count #(
    parameter int CW = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [CW-1:0] load_val,
    input wire logic step,
    input wire logic stop_en,
    input wire logic [CW-1:0] end_val,
    input wire logic [CW-1:0] rst_val,
    output logic [CW-1:0] count,
    output logic hit
);
    logic [CW-1:0] count_r; // present count
    logic [CW-1:0] count_nxt; // count after one step

    assign count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};

    // load beats step; with no step the value simply holds
    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= rst_val;
        end else if (load) begin
            count_r <= load_val;
        end else if (step) begin
            count_r <= count_nxt;
        end
    end

    // last step onto the end value asks the gate to close
    assign hit = step & stop_en & (count_nxt == end_val);
    assign count = count_r;

endmodule : cgc_count

/* src/cgc_top.sv */
// counter gate control: eight channels of soft, hard and internal gates with avalon registers
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module cgc_top
    import cgc_pkg::*;
#(
    parameter int NCH = CGC_NCH,
    parameter int CW = CGC_CW
) (
    input wire logic CLK,
    input wire logic RST,
    // avalon-mm slave
    input wire logic [CGC_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // field signals
    input wire logic [NCH-1:0] HARD_GATE_INPUTS,
    input wire logic [NCH-1:0] COUNT_INPUTS,
    // results
    output logic [NCH-1:0] GATE_OPEN,
    output logic [NCH-1:0] PULSE_OUT
);

    // one channel, end to end:
    // pins pass two sync flops and an edge stage
    // soft gate opens on a rise of its bit only
    // clearing the bit closes the soft gate
    // hard gate follows pin edges, not its level
    // an unconfigured hard gate counts as open
    // internal gate is the and of the two
    // a count edge on an open gate steps the counter, except in a reload cycle
    // the pulse output shows that step a cycle later
    // cancel reloads the start on every opening edge
    // interrupt keeps the held value
    // gate output and status lag by one cycle
    // limitation: pin pulses under two clocks may be lost
    // pins are taken as free of bounce; no filter
    // trade-off: one wait cycle keeps read data in a flop

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0] soft_gate_ctrl_bits_r; // software level per channel
    logic [7:0] soft_prev_r; // last seen level, for the rise
    logic [7:0] hwen_r; // hard gate configured
    logic [7:0] cancel_r; // cancel or interrupt selection
    logic [7:0] auto_r; // auto stop enable
    logic [CW-1:0] start_r [NCH]; // start values
    logic [CW-1:0] end_r [NCH]; // end values

    // gate state
    logic [NCH-1:0] soft_open_r; // soft gate open
    logic [NCH-1:0] hard_open_r; // hard gate open
    logic [NCH-1:0] gate_prev_r; // internal gate one cycle ago
    logic [NCH-1:0] gate_int; // internal gate now
    logic [NCH-1:0] soft_rise; // control bit went 0 to 1
    logic [NCH-1:0] reopen; // internal gate opening edge
    logic [NCH-1:0] load; // counter reload request
    logic [NCH-1:0] step; // pulse that reaches the counter
    logic [NCH-1:0] hit; // end value reached, close the gate
    logic [NCH-1:0] load_cmd; // software load strobe
    logic [CW-1:0] count [NCH]; // counter values

    // synchronised field inputs
    logic [NCH-1:0] hard_rise; // hard pin went 0 to 1
    logic [NCH-1:0] hard_fall; // hard pin went 1 to 0
    logic [NCH-1:0] cnt_rise; // one count pulse

    // bus handshake
    logic wait_r; // waitrequest, high while idle
    logic [31:0] rdata_r; // read data flop
    logic [31:0] rdata_nxt; // decoded read value
    logic wr_go; // write takes effect this edge
    logic [2:0] blk; // coarse address block
    logic [2:0] idx; // word index inside a block
    cgc_stat_t stat; // status word

    // ------------------------------------------------------------------
    // input synchronisers: every field signal passes two flops first
    // ------------------------------------------------------------------
    cgc_sync #(
        .W(NCH)
    ) u_sync_hard (
        .clk(CLK),
        .rst(RST),
        .din(HARD_GATE_INPUTS),
        .lvl(),
        .rise(hard_rise),
        .fall(hard_fall)
    );

    // count pins need only the rise
    cgc_sync #(
        .W(NCH)
    ) u_sync_cnt (
        .clk(CLK),
        .rst(RST),
        .din(COUNT_INPUTS),
        .lvl(),
        .rise(cnt_rise),
        .fall()
    );

    // ------------------------------------------------------------------
    // avalon decode
    // ------------------------------------------------------------------
    assign blk = AVS_ADDRESS[7:5];
    assign idx = AVS_ADDRESS[4:2];
    // a write lands at the edge where the master sees waitrequest low
    assign wr_go = AVS_WRITE & ~wait_r;

    // byte lane merge for a 32-bit register
    // lanes with their enable low keep the old byte
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // fixed latency: take at one edge, answer at the next;
    // the master holds its request until waitrequest is low
    // one wait cycle per access: waitrequest drops for exactly one cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_r <= 1'b1;
        end else if ((AVS_READ | AVS_WRITE) & wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    // status word gathers live gate states
    // upper status bits read zero
    always_comb begin
        stat.gate = '0;
        stat.soft_open = '0;
        stat.hard_open = '0;
        stat.gate[NCH-1:0] = gate_prev_r;
        stat.soft_open[NCH-1:0] = soft_open_r;
        stat.hard_open[NCH-1:0] = hard_open_r;
    end

    // read mux; unmapped addresses read zero
    // count and status are live values at the take edge
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (blk == 3'h0) begin
            unique case (AVS_ADDRESS)
                CGC_OFS_SOFT: rdata_nxt = {24'h000000, soft_gate_ctrl_bits_r};
                CGC_OFS_HWEN: rdata_nxt = {24'h000000, hwen_r};
                CGC_OFS_CANCEL: rdata_nxt = {24'h000000, cancel_r};
                CGC_OFS_AUTO: rdata_nxt = {24'h000000, auto_r};
                CGC_OFS_STATUS: rdata_nxt = {8'h00, stat};
                default: rdata_nxt = 32'h00000000; // load strobe and holes
            endcase
        end else if (blk == CGC_BLK_START) begin
            rdata_nxt = 32'(start_r[idx]);
        end else if (blk == CGC_BLK_END) begin
            rdata_nxt = 32'(end_r[idx]);
        end else if (blk == CGC_BLK_COUNT) begin
            rdata_nxt = 32'(count[idx]);
        end
    end

    // read data is captured as waitrequest falls, so it stands when sampled
    // a write leaves this flop untouched
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= 32'h00000000;
        end else if (AVS_READ & wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // only byte lane 0 carries the eight channel bits
    always_ff @(posedge CLK) begin
        if (RST) begin
            soft_gate_ctrl_bits_r <= CGC_RST_SOFT;
            hwen_r <= CGC_RST_HWEN;
            cancel_r <= CGC_RST_CANCEL;
            auto_r <= CGC_RST_AUTO;
        end else if (wr_go & AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == CGC_OFS_SOFT) begin
                soft_gate_ctrl_bits_r <= AVS_WRITEDATA[7:0];
            end
            if (AVS_ADDRESS == CGC_OFS_HWEN) begin
                hwen_r <= AVS_WRITEDATA[7:0];
            end
            if (AVS_ADDRESS == CGC_OFS_CANCEL) begin
                cancel_r <= AVS_WRITEDATA[7:0];
            end
            if (AVS_ADDRESS == CGC_OFS_AUTO) begin
                auto_r <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // load strobe is a one-cycle pulse, never stored
    // it and a cancel reload write the same start value,
    // so the two sources never conflict
    always_comb begin
        load_cmd = '0;
        if (wr_go & AVS_BYTEENABLE[0] & (AVS_ADDRESS == CGC_OFS_LOAD)) begin
            load_cmd = AVS_WRITEDATA[NCH-1:0];
        end
    end

    // previous soft level, so holding the bit high is not a new rise
    // its reset equals the bit's reset: no false rise
    always_ff @(posedge CLK) begin
        if (RST) begin
            soft_prev_r <= CGC_RST_SOFT;
        end else begin
            soft_prev_r <= soft_gate_ctrl_bits_r;
        end
    end

    // ------------------------------------------------------------------
    // per channel gate logic
    // ------------------------------------------------------------------
    // one copy per channel; channels share only the bus
    // decode and the synchronisers
    // auto stop clears only the soft gate, so a fresh
    // 0 to 1 of the bit is needed to count again
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        cgc_cfg_t cfg; // this channel's configuration

        assign cfg.hw_en = hwen_r[ch];
        assign cfg.cancel = cancel_r[ch];
        assign cfg.auto_stop = auto_r[ch];

        // start and end value words, byte lanes honoured
        always_ff @(posedge CLK) begin
            if (RST) begin
                start_r[ch] <= CW'(CGC_RST_START);
                end_r[ch] <= CW'(CGC_RST_END);
            end else if (wr_go & (idx == 3'(ch))) begin
                if (blk == CGC_BLK_START) begin
                    start_r[ch] <= CW'(be_merge(32'(start_r[ch]), AVS_WRITEDATA,
                                                AVS_BYTEENABLE));
                end
                if (blk == CGC_BLK_END) begin
                    end_r[ch] <= CW'(be_merge(32'(end_r[ch]), AVS_WRITEDATA,
                                              AVS_BYTEENABLE));
                end
            end
        end

        assign soft_rise[ch] = soft_gate_ctrl_bits_r[ch] & ~soft_prev_r[ch];

        // soft gate: the rise opens and wins over an end value close
        always_ff @(posedge CLK) begin
            if (RST) begin
                soft_open_r[ch] <= 1'b0;
            end else if (~soft_gate_ctrl_bits_r[ch]) begin
                soft_open_r[ch] <= 1'b0;
            end else if (soft_rise[ch]) begin
                soft_open_r[ch] <= 1'b1;
            end else if (hit[ch]) begin
                soft_open_r[ch] <= 1'b0;
            end
        end

        // hard gate tracks edges only; a level high at reset stays closed
        always_ff @(posedge CLK) begin
            if (RST) begin
                hard_open_r[ch] <= 1'b0;
            end else if (hard_rise[ch]) begin
                hard_open_r[ch] <= 1'b1;
            end else if (hard_fall[ch]) begin
                hard_open_r[ch] <= 1'b0;
            end
        end

        // hard state keeps tracking while unconfigured, so
        // enabling it later uses the pin's real state
        // and of both gates; an unconfigured hard gate counts as open
        assign gate_int[ch] = soft_open_r[ch] & (hard_open_r[ch] | ~cfg.hw_en);

        // gate history for the reopen edge
        always_ff @(posedge CLK) begin
            if (RST) begin
                gate_prev_r[ch] <= 1'b0;
            end else begin
                gate_prev_r[ch] <= gate_int[ch];
            end
        end

        assign reopen[ch] = gate_int[ch] & ~gate_prev_r[ch];
        // cancel reloads on reopen; interrupt keeps the held value
        assign load[ch] = load_cmd[ch] | (reopen[ch] & cfg.cancel);
        // pulses pass only while the internal gate is open
        // load wins, so a pulse in the reload cycle is dropped
        assign step[ch] = cnt_rise[ch] & gate_int[ch] & ~load[ch];

        cgc_count #(
            .CW(CW)
        ) u_count (
            .clk(CLK),
            .rst(RST),
            .load(load[ch]),
            .load_val(start_r[ch]),
            .step(step[ch]),
            .stop_en(cfg.auto_stop),
            .end_val(end_r[ch]),
            .rst_val(CW'(CGC_RST_COUNT)),
            .count(count[ch]),
            .hit(hit[ch])
        );
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    // forwarded pulses trail the counter step by one cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            PULSE_OUT <= '0;
        end else begin
            PULSE_OUT <= step;
        end
    end

    // gate history doubles as the registered gate output
    assign GATE_OPEN = gate_prev_r;
    assign AVS_WAITREQUEST = wait_r;
    assign AVS_READDATA = rdata_r;

endmodule : cgc_top

/* testbench/cgc_top_asserts.sv */
// port level assertions for the counter gate control block
`timescale 1ns/1ps
module cgc_top_asserts
    import cgc_pkg::*;
#(
    parameter int NCH = CGC_NCH,
    parameter int CW = CGC_CW
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [CGC_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [NCH-1:0] HARD_GATE_INPUTS,
    input wire logic [NCH-1:0] COUNT_INPUTS,
    input wire logic [NCH-1:0] GATE_OPEN,
    input wire logic [NCH-1:0] PULSE_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    logic [NCH-1:0] hq_r; // hard levels one cycle ago
    logic [3:0] cause_r; // cycles left in which a gate may still open

    // a write or a hard rise arms a short window; a wider window would hide stray openings
    always_ff @(posedge CLK) begin
        hq_r <= HARD_GATE_INPUTS;
        if (RST) begin
            cause_r <= 4'h0;
        end else if (AVS_WRITE || |(HARD_GATE_INPUTS & ~hq_r)) begin
            cause_r <= 4'hc;
        end else if (cause_r != 4'h0) begin
            cause_r <= cause_r - 4'h1;
        end
    end

    sequence s_take; // request sampled while the slave waits
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_ack; // one low cycle, then back high
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence

    chk_wait_one: assert property (s_take |=> s_ack)
        else $error("waitrequest not low for exactly one cycle");
    chk_ack_cause: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
        else $error("waitrequest fell without a request");
    chk_idle_wait: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
        else $error("waitrequest low while idle");
    chk_rd_stable: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data moved without a read");
    chk_reset_state: assert property ($fell(RST) |->
        AVS_WAITREQUEST && GATE_OPEN == '0 && PULSE_OUT == '0 && AVS_READDATA == 32'h0)
        else $error("outputs not quiet after reset");
    chk_closed_block: assert property ((PULSE_OUT & ~(GATE_OPEN | $past(GATE_OPEN))) == '0)
        else $error("pulse passed a closed gate");
    chk_pulse_single: assert property ((PULSE_OUT & $past(PULSE_OUT)) == '0)
        else $error("one input edge counted twice");
    chk_open_cause: assert property (|(GATE_OPEN & ~$past(GATE_OPEN)) |-> cause_r != 4'h0)
        else $error("gate opened without write or hard rise");

    // per channel: an edge on an open gate reaches the pulse output
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        chk_count_pass: assert property ($rose(COUNT_INPUTS[i]) && GATE_OPEN[i] &&
            $past(GATE_OPEN[i]) |-> ##[1:6] (PULSE_OUT[i] || !GATE_OPEN[i]))
            else $error("count edge lost on an open gate");
    end
endmodule : cgc_top_asserts

bind cgc_top cgc_top_asserts #(.NCH(NCH), .CW(CW)) u_chk (
    .CLK(CLK),
    .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .HARD_GATE_INPUTS(HARD_GATE_INPUTS),
    .COUNT_INPUTS(COUNT_INPUTS),
    .GATE_OPEN(GATE_OPEN),
    .PULSE_OUT(PULSE_OUT)
);

/* testbench/cgc_field.sv */
// field side model: count pulse bursts and hard gate levels
`timescale 1ns/1ps
module cgc_field (
    input wire logic clk,
    input wire logic [7:0] mask,
    input wire logic [7:0] hard_req,
    input wire logic go,
    input wire logic [3:0] n,
    output logic [7:0] cnt_in,
    output logic [7:0] hard_gate,
    output logic busy
);
    logic [3:0] left_r = 4'h0; // pulses still to send
    logic [1:0] ph_r = 2'h0; // phase within one pulse

    // each pulse is two cycles low then two high, so every edge is a fresh transition
    always_ff @(posedge clk) begin
        if (go && !busy) begin
            left_r <= n;
            ph_r <= 2'h0;
        end else if (left_r != 4'h0) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h3) begin
                left_r <= left_r - 4'h1;
            end
        end
    end

    // hard gate lines follow the request one cycle late, like a real switch
    always_ff @(posedge clk) begin
        hard_gate <= hard_req;
    end

    assign cnt_in = (left_r != 4'h0 && ph_r[1]) ? mask : 8'h00;
    assign busy = left_r != 4'h0;
endmodule : cgc_field

/* testbench/counter_gate_control_bench.sv */
// self-checking bench: register sequences and field pulses for the gate control block
`timescale 1ns/1ps
module counter_gate_control_bench
    import cgc_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] adr = 8'h00;
    logic rd_s = 1'h0;
    logic wr_s = 1'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdata;
    logic wait_s;
    logic [7:0] hard_req = 8'h00;
    logic [7:0] f_mask = 8'h00;
    logic f_go = 1'h0;
    logic [3:0] f_n = 4'h0;
    logic [7:0] cnt_in, hard_gate, gate_open, pulse_out;
    logic f_busy;
    logic [3:0] be = 4'hf; // byte enables of the next access
    logic [31:0] pulse_cnt = 32'h0; // forwarded pulses on channel 0
    logic [31:0] q; // last read data
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] ra [9] = '{CGC_OFS_SOFT, CGC_OFS_HWEN, CGC_OFS_CANCEL, CGC_OFS_AUTO,
        CGC_OFS_LOAD, CGC_OFS_STATUS, 8'h40, 8'h60, 8'h20};

    always #5 clk = ~clk;

    // count forwarded pulses; an unknown output is never counted
    always @(posedge clk) begin
        if (pulse_out[0] === 1'h1) begin
            pulse_cnt <= pulse_cnt + 32'h1;
        end
    end

    cgc_top #(.NCH(CGC_NCH), .CW(CGC_CW)) dut (
        .CLK(clk),
        .RST(rst),
        .AVS_ADDRESS(adr),
        .AVS_READ(rd_s),
        .AVS_WRITE(wr_s),
        .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_s),
        .HARD_GATE_INPUTS(hard_gate),
        .COUNT_INPUTS(cnt_in),
        .GATE_OPEN(gate_open),
        .PULSE_OUT(pulse_out)
    );

    cgc_field u_field (
        .clk(clk),
        .mask(f_mask),
        .hard_req(hard_req),
        .go(f_go),
        .n(f_n),
        .cnt_in(cnt_in),
        .hard_gate(hard_gate),
        .busy(f_busy)
    );

    task automatic complete_run;
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // one avalon access: held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        adr <= a;
        wdat <= d;
        wr_s <= w;
        rd_s <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_s !== 1'h0 && n < 40);
        if (n >= 40) begin
            miscompares++;
            complete_run();
        end
        q = rdata;
        rd_s <= 1'h0;
        wr_s <= 1'h0;
        @(posedge clk); // an edge passes before the next request
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'h0, a, 32'h0);
        check(q, exp, what);
    endtask : rd_chk

    // a hard pin change needs five edges: field flop, two sync flops, gate, history; six are waited
    task automatic gate_chk(input logic [7:0] exp);
        repeat (6) @(posedge clk);
        check({24'h0, gate_open}, {24'h0, exp}, "gate");
    endtask : gate_chk

    // send a burst, then let the sync and counter pipeline drain
    task automatic pulses(input logic [7:0] m, input logic [3:0] n);
        int k;
        f_mask <= m;
        f_n <= n;
        f_go <= 1'h1;
        @(posedge clk);
        f_go <= 1'h0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (f_busy !== 1'h0 && k < 100);
        if (k >= 100) begin
            miscompares++;
            complete_run();
        end
        repeat (6) @(posedge clk);
    endtask : pulses

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        // reset values, an unmapped place among them
        foreach (ra[i]) rd_chk(ra[i], ra[i] == 8'h60 ? CGC_RST_END : 32'h0, "reset");
        bus(1'h1, 8'h20, 32'h5);
        rd_chk(8'h20, 32'h0, "unmapped");
        // soft gate alone, interrupt mode
        bus(1'h1, CGC_OFS_SOFT, 32'h1);
        gate_chk(8'h01);
        pulses(8'hff, 4'h5);
        rd_chk(8'h80, 32'h5, "count0");
        rd_chk(8'h84, 32'h0, "count1");
        check(pulse_cnt, 32'h5, "pulse out");
        rd_chk(CGC_OFS_STATUS, 32'h101, "status");
        bus(1'h1, CGC_OFS_SOFT, 32'h0);
        gate_chk(8'h00);
        pulses(8'h01, 4'h3);
        rd_chk(8'h80, 32'h5, "held");
        check(pulse_cnt, 32'h5, "blocked");
        bus(1'h1, CGC_OFS_SOFT, 32'h1);
        pulses(8'h01, 4'h2);
        rd_chk(8'h80, 32'h7, "resumed");
        // hard gate configured
        bus(1'h1, CGC_OFS_HWEN, 32'h1);
        gate_chk(8'h00);
        hard_req <= 8'h01;
        gate_chk(8'h01);
        pulses(8'h01, 4'h1);
        hard_req <= 8'h00;
        gate_chk(8'h00);
        pulses(8'h01, 4'h2);
        rd_chk(8'h80, 32'h8, "hard");
        bus(1'h1, CGC_OFS_HWEN, 32'h0);
        gate_chk(8'h01);
        // cancel mode reloads the start value on reopening
        bus(1'h1, CGC_OFS_CANCEL, 32'h1);
        bus(1'h1, 8'h40, 32'h64);
        bus(1'h1, CGC_OFS_SOFT, 32'h0);
        bus(1'h1, CGC_OFS_SOFT, 32'h1);
        pulses(8'h01, 4'h3);
        rd_chk(8'h80, 32'h67, "cancel");
        // count value closes the gate; holding the bit does not reopen it
        bus(1'h1, 8'h60, 32'h69);
        bus(1'h1, CGC_OFS_AUTO, 32'h1);
        pulses(8'h01, 4'h4);
        rd_chk(8'h80, 32'h69, "stop");
        gate_chk(8'h00);
        bus(1'h1, CGC_OFS_SOFT, 32'h1);
        gate_chk(8'h00);
        bus(1'h1, CGC_OFS_SOFT, 32'h0);
        bus(1'h1, CGC_OFS_SOFT, 32'h1);
        gate_chk(8'h01);
        rd_chk(8'h80, 32'h64, "reload");
        bus(1'h1, 8'h40, 32'h10);
        bus(1'h1, CGC_OFS_LOAD, 32'h1);
        rd_chk(8'h80, 32'h10, "load");
        be <= 4'h1;
        bus(1'h1, 8'h40, 32'hffffffaa);
        be <= 4'hf;
        rd_chk(8'h40, 32'haa, "byte lane");
        // reset in mid-run
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rd_chk(8'h80, 32'h0, "count reset");
        rd_chk(CGC_OFS_SOFT, 32'h0, "soft reset");
        gate_chk(8'h00);
        complete_run();
    end
endmodule : counter_gate_control_bench
